// ### verilog/cub_unbalance.sv
// Implementation choices: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps
module cub_unbalance #(
  parameter int MAG_W = cub_pkg::CUB_MAG_W,
  parameter int MS_CYCLES = cub_pkg::CUB_MS_CYCLES
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [MAG_W-1:0] phase1_current_magnitude,
  input wire logic [MAG_W-1:0] phase2_current_magnitude,
  input wire logic [MAG_W-1:0] phase3_current_magnitude,
  input wire logic block_input,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic general_start_out,
  output logic general_trip_out,
  output logic irq
);
  import cub_pkg::*;

  logic op_on;
  logic start_only;
  logic [6:0] limit_pct;
  logic [15:0] delay_ms;
  logic [15:0] rated;
  logic [CUB_EV_W-1:0] ev_status;
  logic [CUB_EV_W-1:0] ev_mask;
  logic [MAG_W-1:0] max_mag;
  logic [MAG_W-1:0] min_mag;
  logic unbal;
  logic max_above_min_level;
  logic max_below_fault_level;
  logic enabled;
  logic start_cond;
  logic prev_start;
  logic prev_trip;
  logic [31:0] ms_pre;
  logic [15:0] ms_cnt;
  logic access_done;
  cub_state_type state;
  logic [CUB_EV_W-1:0] ev_set;
  logic [CUB_EV_W-1:0] ev_clr;
  logic [MAG_W+7:0] diff_x100;
  logic [MAG_W+7:0] max_x_lim;
  logic [MAG_W+15:0] max_x_rel;
  logic [MAG_W+7:0] max_x100;
  logic [MAG_W+7:0] rated_x_min;
  logic [MAG_W+7:0] rated_x_flt;
  logic wr_req;
  logic rd_req;
  logic wr_fire;

  cub_minmax #(.W(MAG_W)) u_minmax (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .mag_a(phase1_current_magnitude),
    .mag_b(phase2_current_magnitude),
    .mag_c(phase3_current_magnitude),
    .max_mag(max_mag),
    .min_mag(min_mag)
  );

  assign diff_x100 = (MAG_W + 8)'((max_mag - min_mag) * 8'(100));
  assign max_x_lim = (MAG_W + 8)'(max_mag * limit_pct);
  assign max_x_rel = (MAG_W + 16)'(max_mag * limit_pct * 7'(CUB_RESET_RATIO_PCT));
  assign max_x100 = (MAG_W + 8)'(max_mag * 8'(100));
  assign rated_x_min = (MAG_W + 8)'(rated * 8'(CUB_MIN_PCT));
  assign rated_x_flt = (MAG_W + 8)'(rated * 8'(CUB_MAX_PCT));
  assign max_above_min_level = max_x100 > rated_x_min;
  assign max_below_fault_level = max_x100 < rated_x_flt;
  assign enabled = op_on && !block_input;
  assign start_cond = enabled && unbal && max_above_min_level && max_below_fault_level;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      unbal <= 1'b0;
    end else if (!unbal) begin
      unbal <= diff_x100 > max_x_lim;
    end else begin
      unbal <= (MAG_W + 16)'(diff_x100 * 7'(100)) >= max_x_rel;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ms_pre <= '0;
      ms_cnt <= '0;
    end else if (!start_cond) begin
      ms_pre <= '0;
      ms_cnt <= '0;
    end else if (ms_pre == 32'(MS_CYCLES - 1)) begin
      ms_pre <= '0;
      if (ms_cnt != 16'hFFFF) begin
        ms_cnt <= ms_cnt + 16'h0001;
      end
    end else begin
      ms_pre <= ms_pre + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state <= CUB_IDLE;
    end else begin
      case (state)
        CUB_IDLE: begin
          if (start_cond) begin
            state <= CUB_TIMING;
          end
        end
        CUB_TIMING: begin
          if (!start_cond) begin
            state <= CUB_IDLE;
          end else if (ms_cnt >= delay_ms && !start_only) begin
            state <= CUB_TRIPPED;
          end
        end
        CUB_TRIPPED: begin
          if (!start_cond || start_only) begin
            state <= start_cond ? CUB_TIMING : CUB_IDLE;
          end
        end
        default: state <= CUB_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      general_start_out <= 1'b0;
      general_trip_out <= 1'b0;
      prev_start <= 1'b0;
      prev_trip <= 1'b0;
    end else begin
      general_start_out <= start_cond;
      general_trip_out <= (state == CUB_TRIPPED) && start_cond && !start_only;
      prev_start <= general_start_out;
      prev_trip <= general_trip_out;
    end
  end

  always_comb begin
    ev_set = '0;
    ev_set[CUB_EV_ST_ON] = general_start_out && !prev_start;
    ev_set[CUB_EV_ST_OFF] = !general_start_out && prev_start;
    ev_set[CUB_EV_TR_ON] = general_trip_out && !prev_trip;
    ev_set[CUB_EV_TR_OFF] = !general_trip_out && prev_trip;
  end

  assign wr_req = avs_write && !access_done;
  assign rd_req = avs_read && !access_done;
  // A write lands only at the edge that also sees waitrequest low.
  assign wr_fire = avs_write && !avs_waitrequest;
  assign ev_clr = (wr_fire && avs_address == CUB_ADDR_EVENT && avs_byteenable[0]) ?
    avs_writedata[CUB_EV_W-1:0] : '0;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ev_status <= '0;
    end else begin
      ev_status <= (ev_status & ~ev_clr) | ev_set;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((ev_status & ~ev_clr) | ev_set) & ev_mask);
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      op_on <= 1'b0;
      start_only <= 1'b0;
      limit_pct <= CUB_LIMIT_DEF;
      delay_ms <= CUB_DELAY_DEF;
      rated <= CUB_RATED_DEF;
      ev_mask <= '0;
    end else if (wr_fire) begin
      case (avs_address)
        CUB_ADDR_CTRL: begin
          if (avs_byteenable[0]) begin
            op_on <= avs_writedata[CUB_CTRL_ON_BIT];
            start_only <= avs_writedata[CUB_CTRL_SONLY_BIT];
          end
          if (avs_byteenable[2]) begin
            rated[7:0] <= avs_writedata[23:16];
          end
          if (avs_byteenable[3]) begin
            rated[15:8] <= avs_writedata[31:24];
          end
        end
        CUB_ADDR_LIMIT: begin
          if (avs_byteenable[0] && avs_writedata[6:0] >= CUB_LIMIT_MIN &&
              avs_writedata[6:0] <= CUB_LIMIT_MAX && avs_writedata[7] == 1'b0) begin
            limit_pct <= avs_writedata[6:0];
          end
        end
        CUB_ADDR_DELAY: begin
          if (&avs_byteenable[1:0] && avs_writedata[15:0] >= CUB_DELAY_MIN &&
              avs_writedata[15:0] <= CUB_DELAY_MAX) begin
            delay_ms <= avs_writedata[15:0];
          end
        end
        CUB_ADDR_MASK: begin
          if (avs_byteenable[0]) begin
            ev_mask <= avs_writedata[CUB_EV_W-1:0];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Each access waits one cycle, then completes with waitrequest low.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      access_done <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata <= '0;
    end else begin
      access_done <= (wr_req || rd_req);
      avs_waitrequest <= !(wr_req || rd_req);
      if (rd_req) begin
        case (avs_address)
          CUB_ADDR_CTRL: avs_readdata <= {rated, 14'h0000, start_only, op_on};
          CUB_ADDR_LIMIT: avs_readdata <= {25'h0000000, limit_pct};
          CUB_ADDR_DELAY: avs_readdata <= {16'h0000, delay_ms};
          CUB_ADDR_STATE: avs_readdata <= {28'h0000000, max_below_fault_level,
            max_above_min_level, general_trip_out, general_start_out};
          CUB_ADDR_EVENT: avs_readdata <= {28'h0000000, ev_status};
          CUB_ADDR_MASK: avs_readdata <= {28'h0000000, ev_mask};
          default: avs_readdata <= '0;
        endcase
      end
    end
  end
endmodule : cub_unbalance

// ### verilog/cub_pkg.sv
// Operation
// - Find largest and smallest phase magnitude; start when difference exceeds limit.
// - Difference is taken as a percentage of the largest magnitude.
// - Start only while largest magnitude is above ten percent of rated.
// - Start only while largest magnitude is below one hundred fifty percent of rated.
// - Operation Off after reset keeps start and trip inactive.
// - Blocking input suppresses start and trip; outside logic drives it.
// - Trip after configured delay with condition persisting, when tripping enabled.
// - Start-only flag forbids trip but keeps start; false after reset.
// - Unbalance limit 10 to 90 percent, step one, default 50.
// - Trip delay 100 to 60000 ms, default 1000, counted from condition onset.
// - General start and general trip outputs, also readable as status.
// - Every rising and falling edge of start and trip raises an event.
package cub_pkg;
  localparam int CUB_MAG_W = 16;
  localparam logic [15:0] CUB_RATED_DEF = 16'h1000;
  localparam int CUB_CLK_MHZ = 250;
  localparam int CUB_MS_CYCLES = CUB_CLK_MHZ * 1000;
  localparam int CUB_MIN_PCT = 10;
  localparam int CUB_MAX_PCT = 150;
  localparam int CUB_RESET_RATIO_PCT = 95;
  localparam logic [6:0] CUB_LIMIT_MIN = 7'h0A;
  localparam logic [6:0] CUB_LIMIT_MAX = 7'h5A;
  localparam logic [6:0] CUB_LIMIT_DEF = 7'h32;
  localparam logic [15:0] CUB_DELAY_MIN = 16'h0064;
  localparam logic [15:0] CUB_DELAY_MAX = 16'hEA60;
  localparam logic [15:0] CUB_DELAY_DEF = 16'h03E8;
  localparam logic [3:0] CUB_ADDR_CTRL = 4'h0;
  localparam logic [3:0] CUB_ADDR_LIMIT = 4'h1;
  localparam logic [3:0] CUB_ADDR_DELAY = 4'h2;
  localparam logic [3:0] CUB_ADDR_STATE = 4'h3;
  localparam logic [3:0] CUB_ADDR_EVENT = 4'h4;
  localparam logic [3:0] CUB_ADDR_MASK = 4'h5;
  localparam int CUB_CTRL_ON_BIT = 0;
  localparam int CUB_CTRL_SONLY_BIT = 1;
  localparam int CUB_EV_W = 4;
  localparam int CUB_EV_ST_ON = 0;
  localparam int CUB_EV_ST_OFF = 1;
  localparam int CUB_EV_TR_ON = 2;
  localparam int CUB_EV_TR_OFF = 3;
  typedef enum logic [1:0] {CUB_IDLE, CUB_TIMING, CUB_TRIPPED} cub_state_type;
endpackage : cub_pkg

// ### verilog/cub_minmax.sv
`timescale 1ns/1ps
module cub_minmax #(
  parameter int W = 16
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [W-1:0] mag_a,
  input wire logic [W-1:0] mag_b,
  input wire logic [W-1:0] mag_c,
  output logic [W-1:0] max_mag,
  output logic [W-1:0] min_mag
);
  logic [W-1:0] ab_hi;
  logic [W-1:0] ab_lo;
  assign ab_hi = (mag_a > mag_b) ? mag_a : mag_b;
  assign ab_lo = (mag_a > mag_b) ? mag_b : mag_a;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      max_mag <= '0;
      min_mag <= '0;
    end else begin
      max_mag <= (mag_c > ab_hi) ? mag_c : ab_hi;
      min_mag <= (mag_c < ab_lo) ? mag_c : ab_lo;
    end
  end
endmodule : cub_minmax

// ### testbench/cub_unbalance_assertions.sv
`timescale 1ns/1ps
module cub_unbalance_checker #(
  parameter int MS_CYCLES = 250000
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic block_input,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic general_start_out,
  input wire logic general_trip_out
);
  localparam int MIN_RUN = 100 * MS_CYCLES - 8;
  int st_cnt;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // Counts how long start has stood without a break.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st_cnt <= 0;
    end else begin
      st_cnt <= general_start_out ? st_cnt + 1 : 0;
    end
  end
  chk_block_start: assert property (block_input [*2] |=> !general_start_out)
    else $error("start while blocked");
  chk_block_trip: assert property (block_input [*2] |=> !general_trip_out)
    else $error("trip while blocked");
  chk_trip_start: assert property (general_trip_out |-> $past(general_start_out))
    else $error("trip without start");
  chk_trip_delay: assert property ($rose(general_trip_out) |-> st_cnt >= MIN_RUN)
    else $error("trip too early");
  chk_start_off_trip: assert property (!general_start_out [*2] |-> !general_trip_out)
    else $error("trip kept after start dropped");
  chk_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("no answer after one wait");
  chk_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("answer held too long");
  chk_reset_quiet: assert property ($rose(nrst) |-> !general_start_out && !general_trip_out)
    else $error("output active after reset");
  cov_trip: cover property ($rose(general_trip_out));
  cov_release: cover property ($fell(general_start_out));
  cov_block: cover property (block_input && general_start_out);
endmodule : cub_unbalance_checker
bind cub_unbalance cub_unbalance_checker #(.MS_CYCLES(MS_CYCLES)) u_chk (
  .clk_sys(clk_sys), .nrst(nrst), .block_input(block_input), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
  .general_start_out(general_start_out), .general_trip_out(general_trip_out)
);

// ### testbench/cub_far_model.sv
`timescale 1ns/1ps
module cub_far_model (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [15:0] lvl_a,
  input wire logic [15:0] lvl_b,
  input wire logic [15:0] lvl_c,
  input wire logic blk_req,
  output logic [15:0] mag_a,
  output logic [15:0] mag_b,
  output logic [15:0] mag_c,
  output logic block_input
);
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      mag_a <= 16'h0000;
      mag_b <= 16'h0000;
      mag_c <= 16'h0000;
    end else begin
      mag_a <= lvl_a;
      mag_b <= lvl_b;
      mag_c <= lvl_c;
    end
  end
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      block_input <= 1'b0;
    end else begin
      block_input <= blk_req;
    end
  end
endmodule : cub_far_model

// ### testbench/test_current_unbalance_protection.sv
`timescale 1ns/1ps
module test_current_unbalance_protection;
  import cub_pkg::*;
  logic clk_sys, nrst, blk_req, blk, rd_en, wr_en, wait_req, st, tr, irq;
  logic [15:0] lvl_a, lvl_b, lvl_c, p1, p2, p3;
  logic [3:0] addr;
  logic [31:0] wdata, rdata, rd;
  int n_fail, checks_done, n;
  cub_far_model u_far (.clk_sys(clk_sys), .nrst(nrst), .lvl_a(lvl_a), .lvl_b(lvl_b),
    .lvl_c(lvl_c), .blk_req(blk_req), .mag_a(p1), .mag_b(p2), .mag_c(p3), .block_input(blk));
  cub_unbalance #(.MS_CYCLES(10)) dut (.clk_sys(clk_sys), .nrst(nrst),
    .phase1_current_magnitude(p1), .phase2_current_magnitude(p2),
    .phase3_current_magnitude(p3), .block_input(blk), .avs_address(addr), .avs_read(rd_en),
    .avs_write(wr_en), .avs_writedata(wdata), .avs_byteenable(4'hF), .avs_readdata(rdata),
    .avs_waitrequest(wait_req), .general_start_out(st), .general_trip_out(tr), .irq(irq));
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  task close_out();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : close_out
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task wt(input int k);
    repeat (k) @(posedge clk_sys);
  endtask : wt
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr_en <= w;
    rd_en <= !w;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (wait_req !== 1'b0 && n < 50);
    if (n >= 50) begin
      n_fail++;
      close_out();
    end
    rd = rdata;
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    wt(1);
  endtask : bus
  task mags(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c);
    lvl_a <= a;
    lvl_b <= b;
    lvl_c <= c;
    wt(5);
  endtask : mags
  task t_regs();
    bus(0, CUB_ADDR_CTRL, 0);
    chk(rd, 32'h1000_0000);
    bus(0, CUB_ADDR_LIMIT, 0);
    chk(rd, 32'h0000_0032);
    bus(0, CUB_ADDR_DELAY, 0);
    chk(rd, 32'h0000_03E8);
    bus(0, 4'hF, 0);
    chk(rd, 32'h0000_0000);
    mags(16'h1000, 16'h1000, 16'h0400);
    chk(st, 1'b0);
    bus(1, CUB_ADDR_CTRL, 32'h1000_0001);
    bus(1, CUB_ADDR_LIMIT, 32'h0000_005B);
    bus(0, CUB_ADDR_LIMIT, 0);
    chk(rd, 32'h0000_0032);
    bus(1, CUB_ADDR_DELAY, 32'h0000_0063);
    bus(1, CUB_ADDR_DELAY, 32'h0000_0064);
    bus(0, CUB_ADDR_DELAY, 0);
    chk(rd, 32'h0000_0064);
    $display("registers test done");
  endtask : t_regs
  task t_diff();
    mags(16'h1000, 16'h1000, 16'h1000);
    chk(st, 1'b0);
    mags(16'h1000, 16'h1000, 16'h0800);
    chk(st, 1'b0);
    mags(16'h1000, 16'h07FF, 16'h1000);
    chk(st, 1'b1);
    mags(16'h0800, 16'h1000, 16'h1000);
    chk(st, 1'b1);
    mags(16'h0880, 16'h1000, 16'h1000);
    chk(st, 1'b0);
    mags(16'h0190, 16'h0000, 16'h0190);
    chk(st, 1'b0);
    mags(16'h019A, 16'h0000, 16'h019A);
    chk(st, 1'b1);
    mags(16'h1800, 16'h1800, 16'h0000);
    chk(st, 1'b0);
    mags(16'h17FF, 16'h17FF, 16'h0000);
    chk(st, 1'b1);
    $display("difference and band test done");
  endtask : t_diff
  task t_trip();
    mags(16'h1000, 16'h1000, 16'h1000);
    bus(1, CUB_ADDR_MASK, 32'h0000_000F);
    bus(1, CUB_ADDR_EVENT, 32'h0000_000F);
    lvl_c <= 16'h0000;
    n = 0;
    while (tr !== 1'b1 && n < 1100) begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 1100) begin
      n_fail++;
      close_out();
    end
    chk(n >= 1000 && n <= 1010, 1);
    chk(irq, 1'b1);
    bus(0, CUB_ADDR_EVENT, 0);
    chk(rd, 32'h0000_0005);
    bus(0, CUB_ADDR_STATE, 0);
    chk(rd, 32'h0000_000F);
    bus(1, CUB_ADDR_CTRL, 32'h1000_0003);
    wt(3);
    chk({st, tr}, 2'b10);
    blk_req <= 1'b1;
    wt(4);
    chk(st, 1'b0);
    bus(0, CUB_ADDR_EVENT, 0);
    chk(rd, 32'h0000_000F);
    bus(1, CUB_ADDR_EVENT, 32'h0000_000F);
    wt(2);
    chk(irq, 1'b0);
    blk_req <= 1'b0;
    $display("trip test done");
  endtask : t_trip
  task t_reset();
    nrst <= 1'b0;
    wt(2);
    chk({st, tr, irq}, 3'b000);
    nrst <= 1'b1;
    wt(8);
    chk(st, 1'b0);
    bus(0, CUB_ADDR_CTRL, 0);
    chk(rd, 32'h1000_0000);
    $display("reset test done");
  endtask : t_reset
  initial begin
    nrst = 1'b0;
    {blk_req, rd_en, wr_en} = 3'h0;
    {lvl_a, lvl_b, lvl_c} = 48'h0;
    addr = 4'h0;
    wdata = 32'h0;
    n_fail = 0;
    checks_done = 0;
    wt(8);
    nrst <= 1'b1;
    wt(1);
    t_regs();
    t_diff();
    t_trip();
    t_reset();
    close_out();
  end
endmodule : test_current_unbalance_protection
